// >>> hw/utopia_pkg.sv
package utopia_pkg;
    // ----------
    // widths and timing
    // ----------
    localparam int ADDR_W = 3;
    localparam int BYTE_W = 8;
    localparam int SYS_CLK_NS = 25;
    localparam int LINK_CLK_NS = 200;
    localparam int LINK_DIV = LINK_CLK_NS / SYS_CLK_NS;
    localparam int LINK_HALF = LINK_DIV / 2;
    localparam int RESET_MATCH_EDGES = 8;
    localparam logic [2:0] RESET_CNT_LAST = 3'(RESET_MATCH_EDGES - 1);
    localparam logic [3:0] HOST_RESET_HOLD = 4'(RESET_MATCH_EDGES + 2);
    localparam int DIR_TX = 0;
    localparam int DIR_RX = 1;
    // ----------
    // controller register map
    // ----------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TX_DATA = 8'h04;
    localparam logic [7:0] REG_RX_CMD = 8'h08;
    localparam logic [7:0] REG_RESET_CMD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
    localparam logic [7:0] REG_IRQ_MASK = 8'h18;
    localparam int CTRL_TX_ADDR_LSB = 0;
    localparam int CTRL_RX_ADDR_LSB = 4;
    localparam int CTRL_CASCADE_BIT = 8;
    localparam logic [8:0] CTRL_RESET = 9'h000;
    localparam int STAT_TX_FLAGS_LSB = 0;
    localparam int STAT_RX_FLAGS_LSB = 4;
    localparam int STAT_RX_BYTE_LSB = 8;
    localparam int STAT_BUSY_BIT = 16;
    localparam int IRQ_W = 3;
    localparam int IRQ_TX_DONE = 0;
    localparam int IRQ_RX_DONE = 1;
    localparam int IRQ_RESET_DONE = 2;
endpackage

// >>> hw/utopia_if.sv
`timescale 1ns/1ps
interface utopia_if;
    logic tx_host_clock;
    logic rx_host_clock;
    logic [2:0] tx_port_address;
    logic [2:0] rx_port_address;
    logic tx_write_enable_n;
    logic rx_read_enable_n;
    logic tx_fifo_reset_n;
    logic rx_fifo_reset_n;
    logic [7:0] tx_byte_in;
    logic cascade_timing_select;
    logic tx_cell_available;
    logic tx_fifo_full_n;
    logic tx_fifo_empty_n;
    logic tx_flags_oe;
    logic rx_cell_available;
    logic rx_fifo_full_n;
    logic rx_fifo_empty_n;
    logic rx_flags_oe;
    logic [7:0] rx_byte_out;
    logic rx_byte_oe;

    modport dev (
        input tx_host_clock, rx_host_clock, tx_port_address, rx_port_address,
        input tx_write_enable_n, rx_read_enable_n, tx_fifo_reset_n, rx_fifo_reset_n,
        input tx_byte_in, cascade_timing_select,
        output tx_cell_available, tx_fifo_full_n, tx_fifo_empty_n, tx_flags_oe,
        output rx_cell_available, rx_fifo_full_n, rx_fifo_empty_n, rx_flags_oe,
        output rx_byte_out, rx_byte_oe
    );

    modport host (
        output tx_host_clock, rx_host_clock, tx_port_address, rx_port_address,
        output tx_write_enable_n, rx_read_enable_n, tx_fifo_reset_n, rx_fifo_reset_n,
        output tx_byte_in, cascade_timing_select,
        input tx_cell_available, tx_fifo_full_n, tx_fifo_empty_n, tx_flags_oe,
        input rx_cell_available, rx_fifo_full_n, rx_fifo_empty_n, rx_flags_oe,
        input rx_byte_out, rx_byte_oe
    );
endinterface

// >>> hw/utopia_dev_end.sv
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module utopia_dev_end (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    utopia_if.dev link,
    input wire logic [2:0] i_device_address_strap,
    input wire logic i_tx_cell_avail,
    input wire logic i_tx_fifo_full,
    input wire logic i_tx_fifo_empty,
    output logic o_tx_fifo_write,
    output logic [7:0] o_tx_fifo_byte,
    output logic o_tx_reset_hit,
    input wire logic i_rx_cell_avail,
    input wire logic i_rx_fifo_full,
    input wire logic i_rx_fifo_empty,
    input wire logic [7:0] i_rx_fifo_byte,
    output logic o_rx_fifo_read,
    output logic o_rx_reset_hit
);
    // ----------
    // helpers
    // ----------
    function automatic logic addr_matches(input logic [2:0] port_addr, input logic [2:0] strap);
        return port_addr == strap;
    endfunction

    function automatic logic pin_level(input logic asserted, input logic cascade);
        return cascade ? asserted : ~asserted;
    endfunction

    // ----------
    // pin synchronisers
    // ----------
    // bundle: {clock, address[2:0], reset_n, enable_n}
    logic [5:0] pin_bundle [2];
    logic [5:0] bundle_s1 [2];
    logic [5:0] bundle_s2 [2];
    logic [7:0] tx_byte_s1;
    logic [7:0] tx_byte_s2;
    logic [3:0] cfg_s1;
    logic [3:0] cfg_s2;
    logic cascade;
    logic [2:0] strap;

    localparam int DIR_TX_IDX = utopia_pkg::DIR_TX;
    localparam int DIR_RX_IDX = utopia_pkg::DIR_RX;
    assign pin_bundle[DIR_TX_IDX] = {link.tx_host_clock, link.tx_port_address,
                                     link.tx_fifo_reset_n, link.tx_write_enable_n};
    assign pin_bundle[DIR_RX_IDX] = {link.rx_host_clock, link.rx_port_address,
                                     link.rx_fifo_reset_n, link.rx_read_enable_n};

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_byte_s1 <= 8'h00;
            tx_byte_s2 <= 8'h00;
            cfg_s1 <= 4'h0;
            cfg_s2 <= 4'h0;
        end
        else
        begin
            tx_byte_s1 <= link.tx_byte_in;
            tx_byte_s2 <= tx_byte_s1;
            cfg_s1 <= {link.cascade_timing_select, i_device_address_strap};
            cfg_s2 <= cfg_s1;
        end
    end

    assign cascade = cfg_s2[3];
    assign strap = cfg_s2[2:0];

    // ----------
    // per-direction match, reset and selection state
    // ----------
    logic [1:0] port_edge;
    logic [1:0] next_sel;
    logic [1:0] match;
    logic [1:0] reset_hit;
    logic [1:0] selected;
    logic [1:0] flags_oe;

    genvar d;
    generate
        for (d = 0; d < 2; d++)
        begin : g_dir
            logic clk_q;
            logic hit;
            logic rst_hi;
            logic en_act;
            logic prev_en_act;
            logic [2:0] rst_cnt;

            always_ff @(posedge i_clk_sys or negedge i_rst_b)
            begin
                if (!i_rst_b)
                begin
                    bundle_s1[d] <= 6'h3F;
                    bundle_s2[d] <= 6'h3F;
                    clk_q <= 1'b1;
                end
                else
                begin
                    bundle_s1[d] <= pin_bundle[d];
                    bundle_s2[d] <= bundle_s1[d];
                    clk_q <= bundle_s2[d][5];
                end
            end

            assign port_edge[d] = bundle_s2[d][5] & ~clk_q;
            assign hit = addr_matches(bundle_s2[d][4:2], strap);
            assign rst_hi = bundle_s2[d][1];
            assign en_act = pin_level(bundle_s2[d][0], cascade);
            // match may precede the enable
            assign next_sel[d] = selected[d] ? en_act
                               : ((match[d] | (hit & rst_hi)) & en_act & ~prev_en_act);

            always_ff @(posedge i_clk_sys or negedge i_rst_b)
            begin
                if (!i_rst_b)
                begin
                    match[d] <= 1'b0;
                    selected[d] <= 1'b0;
                    prev_en_act <= 1'b0;
                end
                else if (port_edge[d])
                begin
                    match[d] <= hit & rst_hi;
                    selected[d] <= next_sel[d];
                    prev_en_act <= en_act;
                end
            end

            // count only while idle and unselected
            always_ff @(posedge i_clk_sys or negedge i_rst_b)
            begin
                if (!i_rst_b)
                begin
                    rst_cnt <= 3'h0;
                    reset_hit[d] <= 1'b0;
                end
                else if (port_edge[d])
                begin
                    if (hit & ~rst_hi)
                    begin
                        if (~en_act & ~selected[d])
                        begin
                            if (rst_cnt == utopia_pkg::RESET_CNT_LAST)
                            begin
                                reset_hit[d] <= 1'b1;
                            end
                            else
                            begin
                                rst_cnt <= rst_cnt + 3'h1;
                            end
                        end
                        else if (!reset_hit[d])
                        begin
                            rst_cnt <= 3'h0;
                        end
                    end
                    else
                    begin
                        rst_cnt <= 3'h0;
                        reset_hit[d] <= 1'b0;
                    end
                end
            end

            assign flags_oe[d] = match[d] | reset_hit[d];
        end
    endgenerate

    // ----------
    // transmit side
    // ----------
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_tx_fifo_write <= 1'b0;
            o_tx_fifo_byte <= 8'h00;
        end
        else
        begin
            o_tx_fifo_write <= port_edge[DIR_TX_IDX] & next_sel[DIR_TX_IDX];
            if (port_edge[DIR_TX_IDX] & next_sel[DIR_TX_IDX])
            begin
                o_tx_fifo_byte <= tx_byte_s2;
            end
        end
    end

    // reset-hit shows full
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            link.tx_cell_available <= 1'b0;
            link.tx_fifo_full_n <= 1'b1;
            link.tx_fifo_empty_n <= 1'b1;
        end
        else
        begin
            link.tx_cell_available <= i_tx_cell_avail & ~reset_hit[DIR_TX_IDX];
            link.tx_fifo_full_n <= pin_level(i_tx_fifo_full | reset_hit[DIR_TX_IDX], cascade);
            link.tx_fifo_empty_n <= pin_level(i_tx_fifo_empty & ~reset_hit[DIR_TX_IDX], cascade);
        end
    end

    assign link.tx_flags_oe = flags_oe[DIR_TX_IDX];
    assign o_tx_reset_hit = reset_hit[DIR_TX_IDX];

    // ----------
    // receive side
    // ----------
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_rx_fifo_read <= 1'b0;
            link.rx_byte_out <= 8'h00;
        end
        else
        begin
            o_rx_fifo_read <= port_edge[DIR_RX_IDX] & next_sel[DIR_RX_IDX];
            if (port_edge[DIR_RX_IDX] & next_sel[DIR_RX_IDX])
            begin
                link.rx_byte_out <= i_rx_fifo_byte;
            end
        end
    end

    // reset-hit shows empty
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            link.rx_cell_available <= 1'b0;
            link.rx_fifo_full_n <= 1'b1;
            link.rx_fifo_empty_n <= 1'b1;
        end
        else
        begin
            link.rx_cell_available <= i_rx_cell_avail & ~reset_hit[DIR_RX_IDX];
            link.rx_fifo_full_n <= pin_level(i_rx_fifo_full & ~reset_hit[DIR_RX_IDX], cascade);
            link.rx_fifo_empty_n <= pin_level(i_rx_fifo_empty | reset_hit[DIR_RX_IDX], cascade);
        end
    end

    assign link.rx_flags_oe = flags_oe[DIR_RX_IDX];
    assign link.rx_byte_oe = selected[DIR_RX_IDX];
    assign o_rx_reset_hit = reset_hit[DIR_RX_IDX];
endmodule

// >>> hw/utopia_host_end.sv
`timescale 1ns/1ps
module utopia_host_end (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    utopia_if.host link,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_SEL = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_RESET = 5'b10000
    } host_state_t;

    // ----------
    // link clock divider
    // ----------
    logic [2:0] div_cnt;
    logic link_clk;
    logic rise_tick;
    logic fall_tick;

    assign rise_tick = div_cnt == 3'(utopia_pkg::LINK_HALF - 1);
    assign fall_tick = div_cnt == 3'(utopia_pkg::LINK_DIV - 1);

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            div_cnt <= 3'h0;
            link_clk <= 1'b0;
        end
        else
        begin
            div_cnt <= fall_tick ? 3'h0 : div_cnt + 3'h1;
            link_clk <= rise_tick | (link_clk & ~fall_tick);
        end
    end

    assign link.tx_host_clock = link_clk;
    assign link.rx_host_clock = link_clk;

    // ----------
    // registers
    // ----------
    logic [8:0] ctrl;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic [2:0] tx_seen;
    logic [2:0] rx_seen;
    logic [utopia_pkg::IRQ_W-1:0] irq_status;
    logic [utopia_pkg::IRQ_W-1:0] irq_mask;
    logic [utopia_pkg::IRQ_W-1:0] irq_set;
    logic busy;
    logic op_rx;
    logic op_reset;
    logic start;
    host_state_t state;
    logic [3:0] hold_cnt;

    // orders taken only while idle
    assign start = i_wr & ~busy & ((i_addr == utopia_pkg::REG_TX_DATA) | (i_addr == utopia_pkg::REG_RX_CMD)
                 | ((i_addr == utopia_pkg::REG_RESET_CMD) & (i_wdata[1:0] != 2'h0)));

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctrl <= utopia_pkg::CTRL_RESET;
            irq_mask <= 3'h0;
            tx_byte <= 8'h00;
            op_rx <= 1'b0;
            op_reset <= 1'b0;
        end
        else if (i_wr)
        begin
            if (i_addr == utopia_pkg::REG_CTRL)
                ctrl <= i_wdata[8:0];
            if (i_addr == utopia_pkg::REG_IRQ_MASK)
                irq_mask <= i_wdata[utopia_pkg::IRQ_W-1:0];
            if (start)
            begin
                op_reset <= i_addr == utopia_pkg::REG_RESET_CMD;
                op_rx <= (i_addr == utopia_pkg::REG_RX_CMD)
                       | ((i_addr == utopia_pkg::REG_RESET_CMD) & i_wdata[1]);
                if (i_addr == utopia_pkg::REG_TX_DATA)
                    tx_byte <= i_wdata[7:0];
            end
        end
    end

    // set wins over clear
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            irq_status <= 3'h0;
        else if (i_wr & (i_addr == utopia_pkg::REG_IRQ_STATUS))
            irq_status <= (irq_status & ~i_wdata[utopia_pkg::IRQ_W-1:0]) | irq_set;
        else
            irq_status <= irq_status | irq_set;
    end

    assign o_irq = |(irq_status & irq_mask);

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_rdata <= 32'h0000_0000;
        else if (!i_rd)
            o_rdata <= 32'h0000_0000;
        else
        begin
            case (i_addr)
                utopia_pkg::REG_CTRL: o_rdata <= {23'h00_0000, ctrl};
                utopia_pkg::REG_STATUS: o_rdata <= {15'h0000, busy, rx_byte, 1'b0, rx_seen, 1'b0, tx_seen};
                utopia_pkg::REG_IRQ_STATUS: o_rdata <= {29'h0000_0000, irq_status};
                utopia_pkg::REG_IRQ_MASK: o_rdata <= {29'h0000_0000, irq_mask};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // flags sampled at link rise
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_seen <= 3'h0;
            rx_seen <= 3'h0;
        end
        else if (rise_tick)
        begin
            if (link.tx_flags_oe)
                tx_seen <= {link.tx_fifo_empty_n, link.tx_fifo_full_n, link.tx_cell_available};
            if (link.rx_flags_oe)
                rx_seen <= {link.rx_fifo_empty_n, link.rx_fifo_full_n, link.rx_cell_available};
        end
    end

    // ----------
    // transfer sequencer
    // ----------
    logic en_on;
    logic en_off;
    assign en_on = ctrl[utopia_pkg::CTRL_CASCADE_BIT];
    assign en_off = ~en_on;
    assign link.tx_port_address = ctrl[utopia_pkg::CTRL_TX_ADDR_LSB +: 3];
    assign link.rx_port_address = ctrl[utopia_pkg::CTRL_RX_ADDR_LSB +: 3];

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= ST_IDLE;
            busy <= 1'b0;
            hold_cnt <= 4'h0;
            rx_byte <= 8'h00;
            irq_set <= 3'h0;
            link.tx_write_enable_n <= 1'b1;
            link.rx_read_enable_n <= 1'b1;
            link.tx_fifo_reset_n <= 1'b1;
            link.rx_fifo_reset_n <= 1'b1;
            link.tx_byte_in <= 8'h00;
            link.cascade_timing_select <= 1'b0;
        end
        else
        begin
            irq_set <= 3'h0;
            if (start)
                busy <= 1'b1;
            if (state == ST_IDLE)
            begin
                link.cascade_timing_select <= en_on;
                link.tx_write_enable_n <= en_off;
                link.rx_read_enable_n <= en_off;
            end
            if (rise_tick & (state == ST_WAIT) & op_rx)
                rx_byte <= link.rx_byte_out;
            if (fall_tick)
            begin
                case (state)
                    ST_IDLE:
                    begin
                        hold_cnt <= 4'h0;
                        if (busy & op_reset)
                        begin
                            link.tx_fifo_reset_n <= op_rx;
                            link.rx_fifo_reset_n <= ~op_rx;
                            state <= ST_RESET;
                        end
                        else if (busy)
                            state <= ST_ADDR;
                    end
                    ST_ADDR:
                    begin
                        link.tx_write_enable_n <= op_rx ? en_off : en_on;
                        link.rx_read_enable_n <= op_rx ? en_on : en_off;
                        link.tx_byte_in <= tx_byte;
                        state <= ST_SEL;
                    end
                    ST_SEL:
                    begin
                        link.tx_write_enable_n <= en_off;
                        link.rx_read_enable_n <= en_off;
                        state <= ST_WAIT;
                    end
                    ST_WAIT:
                    begin
                        busy <= 1'b0;
                        irq_set[op_rx ? utopia_pkg::IRQ_RX_DONE : utopia_pkg::IRQ_TX_DONE] <= 1'b1;
                        state <= ST_IDLE;
                    end
                    ST_RESET:
                    begin
                        hold_cnt <= hold_cnt + 4'h1;
                        if (hold_cnt == utopia_pkg::HOST_RESET_HOLD - 4'h1)
                        begin
                            link.tx_fifo_reset_n <= 1'b1;
                            link.rx_fifo_reset_n <= 1'b1;
                            busy <= 1'b0;
                            irq_set[utopia_pkg::IRQ_RESET_DONE] <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// >>> sim/utopia_link_checker.sv
`timescale 1ns/1ps
module utopia_link_checker (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [2:0] i_device_address_strap,
    input wire logic tx_host_clock,
    input wire logic rx_host_clock,
    input wire logic [2:0] tx_port_address,
    input wire logic [2:0] rx_port_address,
    input wire logic tx_write_enable_n,
    input wire logic rx_read_enable_n,
    input wire logic tx_fifo_reset_n,
    input wire logic rx_fifo_reset_n,
    input wire logic cascade_timing_select,
    input wire logic tx_cell_available,
    input wire logic tx_fifo_full_n,
    input wire logic tx_flags_oe,
    input wire logic rx_cell_available,
    input wire logic rx_fifo_empty_n,
    input wire logic rx_flags_oe
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    logic [3:0] tx_cnt;
    logic [3:0] rx_cnt;
    wire tx_am = tx_port_address == i_device_address_strap;
    wire rx_am = rx_port_address == i_device_address_strap;
    wire tx_rq = tx_am && !tx_fifo_reset_n && tx_write_enable_n && !cascade_timing_select;
    wire rx_rq = rx_am && !rx_fifo_reset_n && rx_read_enable_n && !cascade_timing_select;
    // ----------
    // count of link edges seen with a reset request
    // ----------
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b) tx_cnt <= 4'h0;
        else if ($rose(tx_host_clock)) tx_cnt <= tx_rq ? tx_cnt + {3'h0, tx_cnt < 4'h8} : 4'h0;
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b) rx_cnt <= 4'h0;
        else if ($rose(rx_host_clock)) rx_cnt <= rx_rq ? rx_cnt + {3'h0, rx_cnt < 4'h8} : 4'h0;
    end
    sequence tx_forced;
        tx_flags_oe && !tx_fifo_full_n && !tx_cell_available;
    endsequence
    sequence rx_forced;
        rx_flags_oe && !rx_fifo_empty_n && !rx_cell_available;
    endsequence
    a_tx_oe_on: assert property ($rose(tx_host_clock) && tx_am && tx_fifo_reset_n |-> ##[1:6] tx_flags_oe)
        else $error("tx flags off");
    a_tx_oe_off: assert property ($rose(tx_host_clock) && !tx_am |-> ##[1:6] !tx_flags_oe)
        else $error("tx flags on");
    a_tx_rst_leave: assert property ($rose(tx_host_clock) && tx_rq && tx_cnt < 4'h7 |-> ##[1:6] !tx_flags_oe)
        else $error("tx match held");
    a_tx_hit_flags: assert property ($rose(tx_host_clock) && tx_rq && tx_cnt == 4'h7 |-> ##[1:6] tx_forced)
        else $error("tx hit flags");
    a_rx_oe_on: assert property ($rose(rx_host_clock) && rx_am && rx_fifo_reset_n |-> ##[1:6] rx_flags_oe)
        else $error("rx flags off");
    a_rx_oe_off: assert property ($rose(rx_host_clock) && !rx_am |-> ##[1:6] !rx_flags_oe)
        else $error("rx flags on");
    a_rx_rst_leave: assert property ($rose(rx_host_clock) && rx_rq && rx_cnt < 4'h7 |-> ##[1:6] !rx_flags_oe)
        else $error("rx match held");
    a_rx_hit_flags: assert property ($rose(rx_host_clock) && rx_rq && rx_cnt == 4'h7 |-> ##[1:6] rx_forced)
        else $error("rx hit flags");
endmodule

// >>> sim/utopia_addr_match_select_test.sv
`timescale 1ns/1ps
module utopia_addr_match_select_test;
    localparam logic [2:0] STRAP = 3'h5;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata, got;
    logic [2:0] tx_st = 3'h0, rx_st = 3'h0, ra, rs;
    logic irq, tx_wr, rx_rd, tx_hit, rx_hit, ro;
    logic [7:0] tx_byte;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0, n_wr = 0, n_rd = 0, n_hit = 0;
    // {port address, fifo status {avail, full, empty}, flags driven}
    logic [6:0] rows [6] = '{{3'h5, 3'h4, 1'b1}, {3'h2, 3'h7, 1'b0}, {3'h5, 3'h3, 1'b1},
        {3'h5, 3'h1, 1'b1}, {3'h4, 3'h2, 1'b0}, {3'h5, 3'h6, 1'b1}};
    utopia_if utopia_if_inst ();
    utopia_dev_end utopia_dev_end_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .link(utopia_if_inst.dev),
        .i_device_address_strap(STRAP), .i_tx_cell_avail(tx_st[2]), .i_tx_fifo_full(tx_st[1]),
        .i_tx_fifo_empty(tx_st[0]), .o_tx_fifo_write(tx_wr), .o_tx_fifo_byte(tx_byte), .o_tx_reset_hit(tx_hit),
        .i_rx_cell_avail(rx_st[2]), .i_rx_fifo_full(rx_st[1]), .i_rx_fifo_empty(rx_st[0]),
        .i_rx_fifo_byte(8'h5C), .o_rx_fifo_read(rx_rd), .o_rx_reset_hit(rx_hit));
    utopia_host_end utopia_host_end_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .link(utopia_if_inst.host),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
    utopia_link_checker utopia_link_checker_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_device_address_strap(STRAP), .tx_host_clock(utopia_if_inst.tx_host_clock),
        .rx_host_clock(utopia_if_inst.rx_host_clock), .tx_port_address(utopia_if_inst.tx_port_address),
        .rx_port_address(utopia_if_inst.rx_port_address), .tx_write_enable_n(utopia_if_inst.tx_write_enable_n),
        .rx_read_enable_n(utopia_if_inst.rx_read_enable_n), .tx_fifo_reset_n(utopia_if_inst.tx_fifo_reset_n),
        .rx_fifo_reset_n(utopia_if_inst.rx_fifo_reset_n),
        .cascade_timing_select(utopia_if_inst.cascade_timing_select),
        .tx_cell_available(utopia_if_inst.tx_cell_available), .tx_fifo_full_n(utopia_if_inst.tx_fifo_full_n),
        .tx_flags_oe(utopia_if_inst.tx_flags_oe), .rx_cell_available(utopia_if_inst.rx_cell_available),
        .rx_fifo_empty_n(utopia_if_inst.rx_fifo_empty_n), .rx_flags_oe(utopia_if_inst.rx_flags_oe));
    initial forever #12.5 i_clk_sys = ~i_clk_sys;
    // ----------
    // monitors, bus tasks and closing report
    // ----------
    always @(negedge i_clk_sys)
    begin
        cycles++;
        n_wr += tx_wr;
        n_rd += rx_rd;
        n_hit += tx_hit + 2 * rx_hit;
        check(32'({tx_wr & tx_hit, rx_rd & rx_hit}), 32'h0);
        if (cycles == 20000)
        begin
            fails++;
            end_of_test();
        end
    end
    function automatic logic [31:0] ctrl(input logic [2:0] a);
        return {25'h0, a, 1'b0, a};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk_sys);
        wr <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk_sys);
        rd <= 1'b0;
        #1 got = rdata;
        @(posedge i_clk_sys);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 300; i++)
        begin
            rd_reg(utopia_pkg::REG_STATUS);
            if (got[utopia_pkg::STAT_BUSY_BIT] === 1'b0) break;
        end
        check(32'(got[utopia_pkg::STAT_BUSY_BIT]), 32'h0);
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        @(posedge i_clk_sys);
        foreach (rows[k])
        begin
            {ra, rs, ro} = rows[k];
            tx_st <= rs;
            rx_st <= ~rs;
            wr_reg(utopia_pkg::REG_CTRL, ctrl(ra));
            repeat (32) @(posedge i_clk_sys);
            check(32'(utopia_if_inst.tx_flags_oe), 32'(ro));
            check(32'(utopia_if_inst.rx_flags_oe), 32'(ro));
            rd_reg(utopia_pkg::REG_STATUS);
            if (ro) check(32'(got[6:0]), {25'h0, rs[0], rs[1], ~rs[2], 1'b0, ~rs[0], ~rs[1], rs[2]});
        end
        i_rst_b <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        check(32'({utopia_if_inst.tx_flags_oe, utopia_if_inst.rx_byte_oe}), 32'h0);
        i_rst_b <= 1'b1;
        @(posedge i_clk_sys);
        rd_reg(utopia_pkg::REG_CTRL);
        check(got, 32'h0);
        rd_reg(8'h1C);
        check(got, 32'h0);
        wr_reg(utopia_pkg::REG_CTRL, ctrl(3'h2));
        wr_reg(utopia_pkg::REG_TX_DATA, 32'h0000_003C);
        wait_idle();
        check(32'(n_wr), 32'h0);
        wr_reg(utopia_pkg::REG_IRQ_STATUS, 32'h0000_0007);
        wr_reg(utopia_pkg::REG_CTRL, ctrl(STRAP));
        repeat (32) @(posedge i_clk_sys);
        wr_reg(utopia_pkg::REG_TX_DATA, 32'h0000_00AB);
        wr_reg(utopia_pkg::REG_TX_DATA, 32'h0000_0011);
        wait_idle();
        check(32'(n_wr), 32'h1);
        check(32'(tx_byte), 32'h0000_00AB);
        check(32'(irq), 32'h0);
        wr_reg(utopia_pkg::REG_IRQ_MASK, 32'h0000_0007);
        check(32'(irq), 32'h1);
        wr_reg(utopia_pkg::REG_IRQ_STATUS, 32'h0000_0001);
        check(32'(irq), 32'h0);
        wr_reg(utopia_pkg::REG_RX_CMD, 32'h0000_0001);
        wait_idle();
        check(32'(n_rd), 32'h1);
        check(32'(got[15:8]), 32'h0000_005C);
        wr_reg(utopia_pkg::REG_IRQ_STATUS, 32'h0000_0007);
        wr_reg(utopia_pkg::REG_RESET_CMD, 32'h0000_0001);
        wait_idle();
        wr_reg(utopia_pkg::REG_RESET_CMD, 32'h0000_0002);
        wait_idle();
        check(32'(n_hit > 0), 32'h1);
        rd_reg(utopia_pkg::REG_IRQ_STATUS);
        check(got, 32'h0000_0004);
        wr_reg(utopia_pkg::REG_CTRL, ctrl(STRAP) | 32'h0000_0100);
        repeat (32) @(posedge i_clk_sys);
        wr_reg(utopia_pkg::REG_TX_DATA, 32'h0000_0066);
        wait_idle();
        check(32'(n_wr), 32'h2);
        end_of_test();
    end
endmodule
